// File: rtl/cct_cfg.svh
`ifndef CCT_CFG_SVH
`define CCT_CFG_SVH

// channel address window: channel n sits at n times the stride
`define CCT_CH_STRIDE 7'h40
`define CCT_CH_SEL_BIT 6

// local offsets inside one channel window
`define CCT_OFF_CMD 6'h20
`define CCT_OFF_STAT 6'h21
`define CCT_OFF_MASK 6'h29
`define CCT_OFF_RX_BYTE_COUNT_LOW 6'h2a
`define CCT_OFF_RX_BYTE_COUNT_HIGH 6'h2b
`define CCT_OFF_CFG 6'h3f

// channel_config_four layout
`define CCT_CFG_RST 8'h00
`define CCT_CFG_WMASK 8'hf3
`define CCT_BIT_QUARTER 7
`define CCT_BIT_ENH 6
`define CCT_BIT_TST 5
`define CCT_BIT_ICD 4
`define CCT_THR_HI 1
`define CCT_THR_LO 0

// command register
`define CCT_BIT_RMC 7

// event status and mask layout
`define CCT_EV_W 3
`define CCT_EV_POOL 0
`define CCT_EV_MSGEND 1
`define CCT_EV_CD 2
`define CCT_STAT_RST 3'h0
`define CCT_MASK_RST 3'h7

// low count bits cleared by RMC per pool size
`define CCT_LOW_32 16'h001f
`define CCT_LOW_16 16'h000f
`define CCT_LOW_4 16'h0003
`define CCT_LOW_2 16'h0001

// core clock divide ratio
`define CCT_CORE_DIV 4
`define CCT_DIV_LAST 2'h3

`define CCT_RD_NONE 8'h00

`endif

// File: rtl/cct_pkg.sv
package cct_pkg;

  typedef enum logic [1:0] {
    CCT_THR_32 = 2'b00,
    CCT_THR_16 = 2'b01,
    CCT_THR_4 = 2'b10,
    CCT_THR_2 = 2'b11
  } cct_thr_t;

  typedef logic [7:0] cct_byte_t;

endpackage : cct_pkg

// File: rtl/cct_div_if.sv
`timescale 1ns/1ps
interface cct_div_if;
  logic quarterSel;
  logic coreTick;
  logic brgTick;

  modport ctl (
    output quarterSel,
    input coreTick,
    input brgTick
  );

  modport div (
    input quarterSel,
    output coreTick,
    output brgTick
  );
endinterface : cct_div_if

// File: rtl/cct_clk_div.sv
`timescale 1ns/1ps
`include "cct_cfg.svh"
module cct_clk_div
  import cct_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic ce,
  cct_div_if.div dv
);

  logic [1:0] div_q;
  logic [1:0] div_d;
  logic coreTick_q;
  logic coreTick_d;
  logic brgTick_q;
  logic brgTick_d;

  initial begin
    if (`CCT_CORE_DIV != 4) begin
      $error("cct_clk_div serves a divide ratio of four only");
    end
  end

  always_comb begin
    if (dv.quarterSel) begin
      div_d = div_q + 2'h1;
      coreTick_d = (div_q == `CCT_DIV_LAST);
    end else begin
      div_d = 2'h0;
      coreTick_d = 1'b1;
    end
    // the rate generator stays on the undivided crystal either way
    brgTick_d = 1'b1;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      div_q <= 2'h0;
      coreTick_q <= 1'b0;
      brgTick_q <= 1'b0;
    end else if (ce) begin
      div_q <= div_d;
      coreTick_q <= coreTick_d;
      brgTick_q <= brgTick_d;
    end
  end

  assign dv.coreTick = coreTick_q;
  assign dv.brgTick = brgTick_q;

endmodule : cct_clk_div

// File: rtl/cct_top.sv
`timescale 1ns/1ps
`include "cct_cfg.svh"
module cct_top
  import cct_pkg::*;
#(
  parameter int NUM_CH = 2,
  parameter int COUNT_W = 12
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [6:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [7:0] regRdData,
  output logic irq,
  input wire logic [NUM_CH-1:0] masterClockOption,
  input wire logic [NUM_CH-1:0] rxByteValid,
  input wire logic [NUM_CH-1:0] rxFrameStart,
  input wire logic [NUM_CH-1:0] rxMessageEnd,
  input wire logic [NUM_CH-1:0] carrierDetect,
  output logic [NUM_CH-1:0] coreTick,
  output logic [NUM_CH-1:0] brgTick,
  output logic [NUM_CH-1:0] enhancedRateSelect,
  output logic [NUM_CH-1:0] testPinSelect,
  output logic [NUM_CH-1:0] carrierActive,
  output logic [NUM_CH-1:0] rxPoolFullEvent
);

  initial begin
    if (NUM_CH < 1 || NUM_CH > 2) begin
      $error("cct_top: NUM_CH must be 1 or 2");
    end
    if (COUNT_W < 5 || COUNT_W > 16) begin
      $error("cct_top: COUNT_W must lie between 5 and 16");
    end
  end

  // local decode shared by all channels
  logic [5:0] locOff;
  logic chSel;
  assign locOff = regAddr[5:0];
  assign chSel = regAddr[`CCT_CH_SEL_BIT];

  cct_byte_t chRd [NUM_CH];
  logic [NUM_CH-1:0] chIrq;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      logic hit;
      logic wrCfg;
      logic wrCmd;
      logic wrStat;
      logic wrMask;
      cct_thr_t thr;
      logic [15:0] lowMask;
      logic [15:0] cntWide;

      logic [7:0] cfg_q;
      logic [7:0] cfg_d;
      logic [`CCT_EV_W-1:0] mask_q;
      logic [`CCT_EV_W-1:0] mask_d;
      logic [`CCT_EV_W-1:0] stat_q;
      logic [`CCT_EV_W-1:0] stat_d;
      logic [`CCT_EV_W-1:0] events;
      logic [COUNT_W-1:0] cnt_q;
      logic [COUNT_W-1:0] cnt_d;
      logic cdRaw_q;
      logic cdRaw_d;
      logic cdAct_q;
      logic cdAct_d;
      logic pool_q;
      logic pool_d;
      logic irq_q;
      logic irq_d;

      cct_div_if dvIf ();

      cct_clk_div u_div (
        .ref_clk(ref_clk),
        .srst(srst),
        .ce(ce),
        .dv(dvIf)
      );

      // each channel decodes only its own window
      assign hit = (chSel == 1'(gi));
      assign wrCfg = regWrStb && hit && (locOff == `CCT_OFF_CFG);
      assign wrCmd = regWrStb && hit && (locOff == `CCT_OFF_CMD);
      assign wrStat = regWrStb && hit && (locOff == `CCT_OFF_STAT);
      assign wrMask = regWrStb && hit && (locOff == `CCT_OFF_MASK);

      assign thr = cct_thr_t'(cfg_q[`CCT_THR_HI:`CCT_THR_LO]);
      // quarter bit is ignored unless the master clock option is on
      assign dvIf.quarterSel = masterClockOption[gi] && cfg_q[`CCT_BIT_QUARTER];

      always_comb begin
        case (thr)
          CCT_THR_32: lowMask = `CCT_LOW_32;
          CCT_THR_16: lowMask = `CCT_LOW_16;
          CCT_THR_4: lowMask = `CCT_LOW_4;
          CCT_THR_2: lowMask = `CCT_LOW_2;
          default: lowMask = `CCT_LOW_32;
        endcase
      end

      always_comb begin
        // unused bits are dropped so they always read back zero
        cfg_d = wrCfg ? (regWrData & `CCT_CFG_WMASK) : cfg_q;
        mask_d = wrMask ? regWrData[`CCT_EV_W-1:0] : mask_q;

        cnt_d = cnt_q;
        if (rxFrameStart[gi]) begin
          cnt_d = '0;
        end else if (wrCmd && regWrData[`CCT_BIT_RMC]) begin
          cnt_d = cnt_q & ~lowMask[COUNT_W-1:0];
        end
        // the counter keeps counting past pool boundaries; an RMC command clears its low bits and a frame start clears all of it
        if (rxByteValid[gi]) begin
          cnt_d = cnt_d + COUNT_W'(1);
        end
        pool_d = rxByteValid[gi] && ((cnt_d & lowMask[COUNT_W-1:0]) == '0);

        cdRaw_d = carrierDetect[gi];
        cdAct_d = carrierDetect[gi] ^ cfg_q[`CCT_BIT_ICD];

        events = '0;
        events[`CCT_EV_POOL] = pool_d;
        events[`CCT_EV_MSGEND] = rxMessageEnd[gi];
        // raw edge, so flipping the invert bit raises no false event
        events[`CCT_EV_CD] = (carrierDetect[gi] != cdRaw_q);
        // a new event beats a clear in the same cycle
        stat_d = (stat_q & ~(wrStat ? regWrData[`CCT_EV_W-1:0] : '0)) | events;
        irq_d = |(stat_d & ~mask_d);
      end

      always_ff @(posedge ref_clk) begin
        if (srst) begin
          cfg_q <= `CCT_CFG_RST;
          mask_q <= `CCT_MASK_RST;
          stat_q <= `CCT_STAT_RST;
          cnt_q <= '0;
          cdRaw_q <= 1'b0;
          cdAct_q <= 1'b0;
          pool_q <= 1'b0;
          irq_q <= 1'b0;
        end else if (ce) begin
          cfg_q <= cfg_d;
          mask_q <= mask_d;
          stat_q <= stat_d;
          cnt_q <= cnt_d;
          cdRaw_q <= cdRaw_d;
          cdAct_q <= cdAct_d;
          pool_q <= pool_d;
          irq_q <= irq_d;
        end
      end

      assign cntWide = 16'(cnt_q);

      always_comb begin
        if (!hit) begin
          chRd[gi] = `CCT_RD_NONE;
        end else begin
          case (locOff)
            `CCT_OFF_CFG: chRd[gi] = cfg_q;
            `CCT_OFF_STAT: chRd[gi] = 8'(stat_q);
            `CCT_OFF_MASK: chRd[gi] = 8'(mask_q);
            `CCT_OFF_RX_BYTE_COUNT_LOW: chRd[gi] = cntWide[7:0];
            `CCT_OFF_RX_BYTE_COUNT_HIGH: chRd[gi] = cntWide[15:8];
            default: chRd[gi] = `CCT_RD_NONE;
          endcase
        end
      end

      assign chIrq[gi] = irq_q;
      assign coreTick[gi] = dvIf.coreTick;
      assign brgTick[gi] = dvIf.brgTick;
      assign enhancedRateSelect[gi] = cfg_q[`CCT_BIT_ENH];
      // left visible so a bad setting shows up outside
      assign testPinSelect[gi] = cfg_q[`CCT_BIT_TST];
      assign carrierActive[gi] = cdAct_q;
      assign rxPoolFullEvent[gi] = pool_q;
    end
  endgenerate

  // bus answer and combined interrupt
  cct_byte_t rdData_q;
  cct_byte_t rdData_d;
  logic irqAll_q;
  logic irqAll_d;

  always_comb begin
    rdData_d = `CCT_RD_NONE;
    if (regRdStb) begin
      for (int i = 0; i < NUM_CH; i++) begin
        rdData_d = rdData_d | chRd[i];
      end
    end
    irqAll_d = |chIrq;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rdData_q <= `CCT_RD_NONE;
      irqAll_q <= 1'b0;
    end else if (ce) begin
      rdData_q <= rdData_d;
      irqAll_q <= irqAll_d;
    end
  end

  assign regRdData = rdData_q;
  assign irq = irqAll_q;

endmodule : cct_top

// File: dv/cct_top_monitor.sv
`timescale 1ns/1ps
module cct_top_monitor #(
  parameter int NUM_CH = 2,
  parameter int COUNT_W = 12
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [6:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  input wire logic [7:0] regRdData,
  input wire logic irq,
  input wire logic [NUM_CH-1:0] masterClockOption,
  input wire logic [NUM_CH-1:0] rxByteValid,
  input wire logic [NUM_CH-1:0] carrierDetect,
  input wire logic [NUM_CH-1:0] coreTick,
  input wire logic [NUM_CH-1:0] brgTick,
  input wire logic [NUM_CH-1:0] enhancedRateSelect,
  input wire logic [NUM_CH-1:0] testPinSelect,
  input wire logic [NUM_CH-1:0] carrierActive,
  input wire logic [NUM_CH-1:0] rxPoolFullEvent
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  AST_BRG_FREE: assert property (!$past(srst) |-> brgTick[0])
    else $error("baud tick dropped");
  AST_CORE_FULL: assert property ((!(|masterClockOption) && !srst)[*2] |-> &coreTick)
    else $error("core tick not full rate");
  // a cleared option may cut a gap short, so it excuses the pattern
  AST_CORE_QUARTER: assert property ($fell(coreTick[0]) && !$past(coreTick[0], 2) |->
    (!coreTick[0] || !masterClockOption[0])[*3] ##1 (coreTick[0] || !masterClockOption[0]))
    else $error("core tick not one in four");
  AST_CARRIER: assert property (!$stable(carrierDetect[0]) && !$past(regWrStb)
    && !$past(srst) |=> !$stable(carrierActive[0]))
    else $error("carrier change lost");
  AST_RD_IDLE: assert property (!$past(regRdStb) |-> regRdData == 8'h00)
    else $error("read data outside slot");
  AST_CFG_RSVD: assert property ($past(regRdStb) && $past(regAddr) inside {7'h3f, 7'h7f}
    |-> regRdData[3:2] == 2'b00)
    else $error("unused config bits set");
  AST_CFG_WRITE: assert property (regWrStb && regAddr == 7'h3f |=>
    {enhancedRateSelect[0], testPinSelect[0]} == $past(regWrData[6:5]))
    else $error("config write not applied");
  AST_CH_INDEP: assert property (regWrStb && regAddr == 7'h3f |=>
    $stable(enhancedRateSelect[NUM_CH-1]))
    else $error("other channel disturbed");
  AST_POOL_PULSE: assert property (rxPoolFullEvent[0] |-> $past(rxByteValid[0])
    ##1 !rxPoolFullEvent[0])
    else $error("pool pulse without byte");
  AST_IRQ_RST: assert property ($past(srst) |-> !irq)
    else $error("irq after reset");
  cover property (rxPoolFullEvent[0]);
  cover property ($rose(irq));
  cover property ($fell(coreTick[0]));
endmodule : cct_top_monitor

// File: dv/testbench.sv
`timescale 1ns/1ps
module testbench
  import cct_pkg::*;
;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic [6:0] regAddr = 7'h00;
  cct_byte_t regWrData = 8'h00;
  logic regWrStb = 1'b0;
  logic regRdStb = 1'b0;
  cct_byte_t regRdData;
  logic irq;
  logic [1:0] masterClockOption = 2'b00;
  logic [1:0] rxByteValid = 2'b00;
  logic [1:0] rxFrameStart = 2'b00;
  logic [1:0] rxMessageEnd = 2'b00;
  logic [1:0] carrierDetect = 2'b00;
  logic [1:0] coreTick, brgTick, enhancedRateSelect, testPinSelect, carrierActive, rxPoolFullEvent;
  int num_errors = 0;
  int n_checks = 0;
  logic rdSeen = 1'b0;
  cct_byte_t expQ[$];
  cct_byte_t v, n, cntCore, cntBrg, cntPool;
  cct_byte_t sizes[4] = '{8'd32, 8'd16, 8'd4, 8'd2};

  cct_top #(.NUM_CH(2), .COUNT_W(12)) cct_top_i (.ref_clk, .srst, .ce, .regAddr, .regWrData,
    .regWrStb, .regRdStb, .regRdData, .irq, .masterClockOption, .rxByteValid, .rxFrameStart,
    .rxMessageEnd, .carrierDetect, .coreTick, .brgTick, .enhancedRateSelect, .testPinSelect,
    .carrierActive, .rxPoolFullEvent);

  always #50 ref_clk = ~ref_clk;

  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // strobes are never lowered here, so back to back calls assign once per edge
  task automatic bus(input logic w, input logic r, input logic [6:0] a, input cct_byte_t d);
    regWrStb <= w;
    regRdStb <= r;
    regAddr <= a;
    regWrData <= d;
    if (r) expQ.push_back(d);
    @(posedge ref_clk);
  endtask : bus

  task automatic idle(input int k);
    regWrStb <= 1'b0;
    regRdStb <= 1'b0;
    repeat (k) @(posedge ref_clk);
  endtask : idle

  task automatic watch(input int k, input int bytes);
    cntCore = 0;
    cntBrg = 0;
    cntPool = 0;
    for (int i = 0; i < k; i++) begin
      rxByteValid <= {1'b0, i < bytes};
      carrierDetect <= 2'($urandom);
      @(negedge ref_clk);
      cntCore = cntCore + coreTick[0];
      cntBrg = cntBrg + brgTick[0];
      cntPool = cntPool + rxPoolFullEvent[0];
      @(posedge ref_clk);
    end
    rxByteValid <= 2'b00;
  endtask : watch

  always @(posedge ref_clk) rdSeen <= regRdStb;
  always @(negedge ref_clk) if (rdSeen) check("regRdData", regRdData, expQ.pop_front());

  initial begin
    #2000000;
    num_errors++;
    end_of_test();
  end

  initial begin
    void'($urandom(32'h63cb));
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    bus(0, 1, 7'h3f, 8'h00);
    bus(0, 1, 7'h7f, 8'h00);
    bus(0, 1, 7'h29, 8'h07);
    bus(0, 1, 7'h22, 8'h00);
    bus(1, 0, 7'h3f, 8'hdf);
    v = 8'($urandom) & 8'hdf;
    bus(1, 0, 7'h7f, v);
    bus(0, 1, 7'h3f, 8'hd3);
    bus(0, 1, 7'h7f, v & 8'hf3);
    idle(1);
    @(negedge ref_clk);
    check("enhancedRateSelect", enhancedRateSelect, {v[6], 1'b1});
    check("testPinSelect", testPinSelect, 2'b00);
    @(posedge ref_clk);
    masterClockOption <= 2'b01;
    watch(8, 0);
    watch(16, 0);
    check("coreTickA", cntCore, 8'd4);
    check("brgTickA", cntBrg, 8'd16);
    masterClockOption <= 2'b00;
    watch(4, 0);
    watch(16, 0);
    check("coreTickA", cntCore, 8'd16);
    @(negedge ref_clk);
    check("carrierActive", carrierActive, carrierDetect ^ {v[4], 1'b1});
    @(posedge ref_clk);
    for (int t = 0; t < 4; t++) begin
      bus(1, 0, 7'h3f, 8'(t));
      rxFrameStart <= 2'b01;
      idle(1);
      rxFrameStart <= 2'b00;
      n = sizes[t] + 8'($urandom % (sizes[t] - 8'd1)) + 8'd1;
      watch(n + 3, n);
      check("poolCount", cntPool, 8'd1);
      bus(0, 1, 7'h2a, n);
      bus(0, 1, 7'h2b, 8'h00);
      bus(1, 0, 7'h20, 8'h80);
      bus(0, 1, 7'h2a, n & ~(sizes[t] - 8'd1));
      idle(1);
    end
    bus(1, 0, 7'h21, 8'h07);
    bus(0, 1, 7'h21, 8'h00);
    rxMessageEnd <= 2'b01;
    idle(1);
    rxMessageEnd <= 2'b00;
    idle(3);
    @(negedge ref_clk);
    check("irqMasked", irq, 1'b0);
    @(posedge ref_clk);
    bus(0, 1, 7'h21, 8'h02);
    bus(1, 0, 7'h29, 8'h05);
    idle(3);
    @(negedge ref_clk);
    check("irqRaised", irq, 1'b1);
    @(posedge ref_clk);
    bus(1, 0, 7'h21, 8'h02);
    idle(3);
    @(negedge ref_clk);
    check("irqCleared", irq, 1'b0);
    @(posedge ref_clk);
    bus(0, 1, 7'h21, 8'h00);
    idle(2);
    end_of_test();
  end
endmodule : testbench

bind cct_top cct_top_monitor #(.NUM_CH(NUM_CH), .COUNT_W(COUNT_W)) cct_top_monitor_i (.ref_clk,
  .srst, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData, .irq, .masterClockOption,
  .rxByteValid, .carrierDetect, .coreTick, .brgTick, .enhancedRateSelect, .testPinSelect,
  .carrierActive, .rxPoolFullEvent);
